// ### core/pmc_cfg_bank.sv
// Purpose: manufacturer configuration and monitoring command bank
// Assumes: a link front end decodes transactions into command strobes
// Notes: read answers one cycle after the strobe, block little-endian
//
// Behaviour
// - log read returns 32 bytes, word 0 lowest, word 15 highest
// - log starts at ramp done, one word each 8 s, sixteenth word 120 s after ramp done
// - options bit 7 demands packet error check on host writes
// - options bit 5 picks linear or non-linear droop
// - options bit 3 enables adaptive ramp and dynamic loop compensation
// - options bit 2 enables dynamic bus voltage
// - options bits 0 and 1 are reserved without function
// - internal temperature offset is a read-only 16-bit word
// - remote calibration reads 4 bytes, offset low, slope high
// - remote config bit 4 selects OR or AND combining
// - remote config bit 2 enables the primary remote input
// - remote config bit 1 sets the remote input polarity
// - remote config bit 0 picks soft stop or quick off
// - temperature compensation block holds thresholds, factors, copper term
// - loop filter block is 27 read/write bytes
// - feed-forward block is four read/write bytes
// - non-linear gain block is 16 read/write bytes
`timescale 1ns/1ps
module pmc_cfg_bank #(
  parameter logic [31:0] LOG_INTERVAL_CYC = pmc_pkg::LOG_INTERVAL_CYC
) (
  input wire logic sys_clk_i, // system clock, 200 MHz
  input wire logic srst_i, // sync reset, active high
  input wire logic [7:0] cmd_code_i, // command code of transaction
  input wire logic wr_stb_i, // write transaction pulse
  input wire logic [255:0] wr_data_i, // write block, byte 0 low
  input wire logic [5:0] wr_len_i, // write byte count
  input wire logic wr_pec_ok_i, // checksum present and valid
  input wire logic rd_stb_i, // read transaction pulse
  output logic [255:0] rd_data_o, // read block, byte 0 low
  output logic [5:0] rd_len_o, // read byte count
  output logic rd_valid_o, // read answer pulse
  output logic cmd_err_o, // refused command pulse
  input wire logic ramp_done_i, // output ramp complete pin
  input wire logic [15:0] status_word_i, // live status word
  input wire logic [15:0] int_temp_ofs_i, // trimmed internal offset
  input wire logic [15:0] remote_ofs_i, // remote sensor offset
  input wire logic [15:0] remote_slope_i, // remote sensor slope
  input wire logic [47:0] temp_comp_i, // trimmed compensation block
  input wire logic primary_remote_input_i, // remote control pin
  input wire logic ctrl_pin_i, // control pin
  input wire logic operation_on_i, // operation command on state
  output logic pec_required_o, // checksum mandatory
  output logic droop_slope_select_o, // 1 non-linear droop
  output logic adaptive_ramp_loop_comp_o, // ramp and loop comp on
  output logic dynamic_bus_voltage_o, // dynamic bus voltage on
  output logic output_on_o, // converter output enabled
  output logic quick_off_o, // 1 off at once, 0 soft stop
  output logic log_done_o, // sixteen words captured
  output logic [31:0] feedforward_o, // feed-forward parameters
  output logic [215:0] loop_filter_o, // loop filter coefficients
  output logic [127:0] nl_gains_o // non-linear filter gains
);

  typedef enum logic [1:0] {
    LOG_WAIT,
    LOG_RUN,
    LOG_HOLD
  } pmc_log_st_t;

  localparam int NPIN = 3;

  logic [NPIN-1:0] pin_raw, s1_ff, s2_ff, s3_ff, lvl_ff;
  logic ramp_prev_ff, log_wr, wr_ok, wr_len_ok, wr_rw_cmd, nxt_rd_known;
  logic rc_asserted, rc_term, nxt_on, on_ff, quick_ff, rd_valid_ff, err_ff;
  logic [7:0] spo_ff, rc_cfg_ff;
  logic [31:0] ff_ff, log_tmr_ff;
  logic [215:0] lf_ff;
  logic [127:0] nlg_ff;
  pmc_log_st_t log_st_ff;
  logic [3:0] log_idx_ff;
  logic [255:0] log_flat, nxt_rd_data, rd_data_ff;
  logic [5:0] nxt_rd_len, rd_len_ff;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  assign pin_raw = {ctrl_pin_i, primary_remote_input_i, ramp_done_i};

  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_sync
      // three stages, level moves once stages two and three agree
      always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
          {s3_ff[g], s2_ff[g], s1_ff[g]} <= 3'h0;
          lvl_ff[g] <= 1'b0;
        end else begin
          {s3_ff[g], s2_ff[g], s1_ff[g]} <= {s2_ff[g], s1_ff[g], pin_raw[g]};
          if (s2_ff[g] == s3_ff[g]) begin
            lvl_ff[g] <= s3_ff[g];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  // length check per writable command
  always_comb begin
    wr_rw_cmd = 1'b1;
    wr_len_ok = 1'b0;
    case (cmd_code_i)
      pmc_pkg::CMD_SPECIAL_OPT: wr_len_ok = wr_len_i == pmc_pkg::LEN_SPECIAL_OPT;
      pmc_pkg::CMD_REMOTE_CTRL: wr_len_ok = wr_len_i == pmc_pkg::LEN_REMOTE_CTRL;
      pmc_pkg::CMD_FEEDFORWARD: wr_len_ok = wr_len_i == pmc_pkg::LEN_FEEDFORWARD;
      pmc_pkg::CMD_LOOP_FILTER: wr_len_ok = wr_len_i == pmc_pkg::LEN_LOOP_FILTER;
      pmc_pkg::CMD_NL_GAINS: wr_len_ok = wr_len_i == pmc_pkg::LEN_NL_GAINS;
      default: wr_rw_cmd = 1'b0;
    endcase
  end

  assign wr_ok = wr_stb_i && wr_rw_cmd && wr_len_ok &&
                 (!spo_ff[pmc_pkg::SPO_PEC_BIT] || wr_pec_ok_i);

  // ----------------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------------
  // option bytes, undefined bits read zero
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      spo_ff <= pmc_pkg::SPO_RST;
      rc_cfg_ff <= pmc_pkg::RC_RST;
    end else if (wr_ok && cmd_code_i == pmc_pkg::CMD_SPECIAL_OPT) begin
      spo_ff <= wr_data_i[7:0] & pmc_pkg::SPO_WR_MASK;
    end else if (wr_ok && cmd_code_i == pmc_pkg::CMD_REMOTE_CTRL) begin
      rc_cfg_ff <= wr_data_i[7:0] & pmc_pkg::RC_WR_MASK;
    end
  end

  // coefficient blocks, whole block per write
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ff_ff <= pmc_pkg::FF_RST;
      lf_ff <= pmc_pkg::LF_RST;
      nlg_ff <= pmc_pkg::NLG_RST;
    end else if (wr_ok && cmd_code_i == pmc_pkg::CMD_FEEDFORWARD) begin
      ff_ff <= wr_data_i[pmc_pkg::W_FEEDFORWARD-1:0];
    end else if (wr_ok && cmd_code_i == pmc_pkg::CMD_LOOP_FILTER) begin
      lf_ff <= wr_data_i[pmc_pkg::W_LOOP_FILTER-1:0];
    end else if (wr_ok && cmd_code_i == pmc_pkg::CMD_NL_GAINS) begin
      nlg_ff <= wr_data_i[pmc_pkg::W_NL_GAINS-1:0];
    end
  end

  // ----------------------------------------------------------------
  // start-up status log
  // ----------------------------------------------------------------
  // capture at ramp done, then every interval
  assign log_wr = (log_st_ff == LOG_RUN) && (log_tmr_ff == 32'h0000_0000);

  // sequencer for capture timing
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      log_st_ff <= LOG_WAIT;
      log_tmr_ff <= 32'h0000_0000;
      log_idx_ff <= 4'h0;
      ramp_prev_ff <= 1'b0;
    end else begin
      ramp_prev_ff <= lvl_ff[0];
      case (log_st_ff)
        LOG_WAIT: begin
          if (lvl_ff[0] && !ramp_prev_ff) begin
            log_st_ff <= LOG_RUN;
            log_tmr_ff <= 32'h0000_0000;
          end
        end
        LOG_RUN: begin
          if (log_wr) begin
            log_tmr_ff <= LOG_INTERVAL_CYC - 32'h0000_0001;
            log_idx_ff <= log_idx_ff + 4'h1;
            if (log_idx_ff == 4'hF) begin
              log_st_ff <= LOG_HOLD;
            end
          end else begin
            log_tmr_ff <= log_tmr_ff - 32'h0000_0001;
          end
        end
        LOG_HOLD: log_st_ff <= LOG_HOLD;
        default: log_st_ff <= LOG_WAIT;
      endcase
    end
  end

  // entry storage, word 0 in low bits
  pmc_log_mem #(
    .DEPTH(pmc_pkg::LOG_WORDS),
    .WIDTH(pmc_pkg::LOG_WORD_W)
  ) u_log_mem (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .wr_en_i(log_wr),
    .wr_idx_i(log_idx_ff),
    .wr_data_i(status_word_i),
    .rd_flat_o(log_flat)
  );

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  // select block and length for the command
  always_comb begin
    nxt_rd_data = '0;
    nxt_rd_len = 6'h00;
    nxt_rd_known = 1'b1;
    case (cmd_code_i)
      pmc_pkg::CMD_STARTUP_LOG: begin
        nxt_rd_data = log_flat;
        nxt_rd_len = pmc_pkg::LEN_STARTUP_LOG;
      end
      pmc_pkg::CMD_SPECIAL_OPT: begin
        nxt_rd_data[7:0] = spo_ff;
        nxt_rd_len = pmc_pkg::LEN_SPECIAL_OPT;
      end
      pmc_pkg::CMD_INT_TEMP_OFS: begin
        nxt_rd_data[15:0] = int_temp_ofs_i;
        nxt_rd_len = pmc_pkg::LEN_INT_TEMP_OFS;
      end
      pmc_pkg::CMD_REMOTE_CAL: begin
        // offset in bytes 0-1, slope in 2-3
        nxt_rd_data[31:0] = {remote_slope_i, remote_ofs_i};
        nxt_rd_len = pmc_pkg::LEN_REMOTE_CAL;
      end
      pmc_pkg::CMD_REMOTE_CTRL: begin
        nxt_rd_data[7:0] = rc_cfg_ff;
        nxt_rd_len = pmc_pkg::LEN_REMOTE_CTRL;
      end
      pmc_pkg::CMD_FEEDFORWARD: begin
        nxt_rd_data[pmc_pkg::W_FEEDFORWARD-1:0] = ff_ff;
        nxt_rd_len = pmc_pkg::LEN_FEEDFORWARD;
      end
      pmc_pkg::CMD_TEMP_COMP: begin
        nxt_rd_data[pmc_pkg::W_TEMP_COMP-1:0] = temp_comp_i;
        nxt_rd_len = pmc_pkg::LEN_TEMP_COMP;
      end
      pmc_pkg::CMD_LOOP_FILTER: begin
        nxt_rd_data[pmc_pkg::W_LOOP_FILTER-1:0] = lf_ff;
        nxt_rd_len = pmc_pkg::LEN_LOOP_FILTER;
      end
      pmc_pkg::CMD_NL_GAINS: begin
        nxt_rd_data[pmc_pkg::W_NL_GAINS-1:0] = nlg_ff;
        nxt_rd_len = pmc_pkg::LEN_NL_GAINS;
      end
      default: nxt_rd_known = 1'b0;
    endcase
  end

  // read answer register, data held until next known read
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rd_data_ff <= '0;
      rd_len_ff <= 6'h00;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= rd_stb_i && nxt_rd_known;
      if (rd_stb_i && nxt_rd_known) begin
        rd_data_ff <= nxt_rd_data;
        rd_len_ff <= nxt_rd_len;
      end
    end
  end

  // refused writes and unknown reads
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      err_ff <= 1'b0;
    end else begin
      err_ff <= (wr_stb_i && !wr_ok) || (rd_stb_i && !nxt_rd_known);
    end
  end

  // ----------------------------------------------------------------
  // remote control combining
  // ----------------------------------------------------------------
  // polarity of the remote input
  assign rc_asserted = rc_cfg_ff[pmc_pkg::RC_POL_BIT] ? lvl_ff[1] : !lvl_ff[1];

  // disabled input becomes neutral for the combine
  assign rc_term = rc_cfg_ff[pmc_pkg::RC_EN_BIT] ? rc_asserted :
                   rc_cfg_ff[pmc_pkg::RC_COMB_BIT];

  // AND or OR with operation and control pin
  assign nxt_on = rc_cfg_ff[pmc_pkg::RC_COMB_BIT] ?
                  (operation_on_i && lvl_ff[2] && rc_term) :
                  (operation_on_i || lvl_ff[2] || rc_term);

  // latch shutdown style when output turns off
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      on_ff <= 1'b0;
      quick_ff <= 1'b0;
    end else begin
      on_ff <= nxt_on;
      if (on_ff && !nxt_on) begin
        quick_ff <= rc_cfg_ff[pmc_pkg::RC_QOFF_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // checksum demand to the link front end
  assign pec_required_o = spo_ff[pmc_pkg::SPO_PEC_BIT];
  assign droop_slope_select_o = spo_ff[pmc_pkg::SPO_DROOP_BIT];
  assign adaptive_ramp_loop_comp_o = spo_ff[pmc_pkg::SPO_ARLC_BIT];
  assign dynamic_bus_voltage_o = spo_ff[pmc_pkg::SPO_DBUS_BIT];
  assign output_on_o = on_ff;
  assign quick_off_o = quick_ff;
  assign log_done_o = log_st_ff == LOG_HOLD;
  assign feedforward_o = ff_ff;
  assign loop_filter_o = lf_ff;
  assign nl_gains_o = nlg_ff;
  assign rd_data_o = rd_data_ff;
  assign rd_len_o = rd_len_ff;
  assign rd_valid_o = rd_valid_ff;
  assign cmd_err_o = err_ff;

endmodule

// ### core/pmc_pkg.sv
// Purpose: shared constants of the manufacturer configuration bank
// Assumes: command codes and field layouts as seen on the host link
// Notes: lengths are in bytes, positions are bit indices
package pmc_pkg;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_STARTUP_LOG = 8'hDF;
  localparam logic [7:0] CMD_SPECIAL_OPT = 8'hE0;
  localparam logic [7:0] CMD_INT_TEMP_OFS = 8'hE1;
  localparam logic [7:0] CMD_REMOTE_CAL = 8'hE2;
  localparam logic [7:0] CMD_REMOTE_CTRL = 8'hE3;
  localparam logic [7:0] CMD_FEEDFORWARD = 8'hE6;
  localparam logic [7:0] CMD_TEMP_COMP = 8'hE7;
  localparam logic [7:0] CMD_LOOP_FILTER = 8'hE8;
  localparam logic [7:0] CMD_NL_GAINS = 8'hE9;

  // ----------------------------------------------------------------
  // block lengths in bytes
  // ----------------------------------------------------------------
  localparam logic [5:0] LEN_STARTUP_LOG = 6'h20;
  localparam logic [5:0] LEN_SPECIAL_OPT = 6'h01;
  localparam logic [5:0] LEN_INT_TEMP_OFS = 6'h02;
  localparam logic [5:0] LEN_REMOTE_CAL = 6'h04;
  localparam logic [5:0] LEN_REMOTE_CTRL = 6'h01;
  localparam logic [5:0] LEN_FEEDFORWARD = 6'h04;
  localparam logic [5:0] LEN_TEMP_COMP = 6'h06;
  localparam logic [5:0] LEN_LOOP_FILTER = 6'h1B;
  localparam logic [5:0] LEN_NL_GAINS = 6'h10;

  // ----------------------------------------------------------------
  // register widths in bits
  // ----------------------------------------------------------------
  localparam int W_BLOCK = 256;
  localparam int W_FEEDFORWARD = 32;
  localparam int W_TEMP_COMP = 48;
  localparam int W_LOOP_FILTER = 216;
  localparam int W_NL_GAINS = 128;

  // ----------------------------------------------------------------
  // special-options fields
  // ----------------------------------------------------------------
  localparam int SPO_PEC_BIT = 7;
  localparam int SPO_DROOP_BIT = 5;
  localparam int SPO_ARLC_BIT = 3;
  localparam int SPO_DBUS_BIT = 2;
  localparam logic [7:0] SPO_WR_MASK = 8'hAC;
  localparam logic [7:0] SPO_RST = 8'h00;

  // ----------------------------------------------------------------
  // remote-control configuration fields
  // ----------------------------------------------------------------
  localparam int RC_COMB_BIT = 4;
  localparam int RC_EN_BIT = 2;
  localparam int RC_POL_BIT = 1;
  localparam int RC_QOFF_BIT = 0;
  localparam logic [7:0] RC_WR_MASK = 8'h17;
  localparam logic [7:0] RC_RST = 8'h00;

  // ----------------------------------------------------------------
  // coefficient reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] FF_RST = 32'h0000_0000;
  localparam logic [215:0] LF_RST = 216'h0;
  localparam logic [127:0] NLG_RST = 128'h0;

  // ----------------------------------------------------------------
  // start-up log timing
  // ----------------------------------------------------------------
  localparam int LOG_WORDS = 16;
  localparam int LOG_WORD_W = 16;
  localparam longint unsigned CLK_HZ = 200_000_000;
  localparam longint unsigned LOG_INTERVAL_S = 8;
  localparam longint unsigned LOG_INTERVAL_CYC_L = LOG_INTERVAL_S * CLK_HZ;
  localparam logic [31:0] LOG_INTERVAL_CYC = LOG_INTERVAL_CYC_L[31:0];

endpackage

// ### core/pmc_log_mem.sv
// Purpose: storage for the start-up status log words
// Assumes: one write port, all words visible as one flat register view
// Notes: entries clear on reset and change only on a write
`timescale 1ns/1ps
module pmc_log_mem #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 16
) (
  input wire logic sys_clk_i, // system clock
  input wire logic srst_i, // sync reset, active high
  input wire logic wr_en_i, // write one entry
  input wire logic [$clog2(DEPTH)-1:0] wr_idx_i, // entry index
  input wire logic [WIDTH-1:0] wr_data_i, // entry data
  output logic [DEPTH*WIDTH-1:0] rd_flat_o // entry 0 in low bits
);

  logic [WIDTH-1:0] mem_ff [DEPTH];

  // ----------------------------------------------------------------
  // entry storage
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_ent
      // one word per entry, held until written
      always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
          mem_ff[g] <= '0;
        end else if (wr_en_i && (wr_idx_i == g)) begin
          mem_ff[g] <= wr_data_i;
        end
      end
      assign rd_flat_o[g*WIDTH +: WIDTH] = mem_ff[g];
    end
  endgenerate

endmodule

// ### testbench/pmc_cfg_checker.sv
// Purpose: concurrent checks on the configuration bank ports
// Assumes: bound to pmc_cfg_bank, one clock domain
// Notes: answers are judged one cycle after the taken strobe
`timescale 1ns/1ps
module pmc_cfg_checker (
  input wire logic sys_clk_i, // system clock
  input wire logic srst_i, // sync reset
  input wire logic [7:0] cmd_code_i, // command code
  input wire logic wr_stb_i, // write pulse
  input wire logic [255:0] wr_data_i, // write block
  input wire logic [5:0] wr_len_i, // write byte count
  input wire logic wr_pec_ok_i, // checksum valid
  input wire logic rd_stb_i, // read pulse
  input wire logic [255:0] rd_data_o, // read block
  input wire logic [5:0] rd_len_o, // read byte count
  input wire logic rd_valid_o, // read answer
  input wire logic cmd_err_o, // refused command
  input wire logic [15:0] remote_ofs_i, // remote offset
  input wire logic [15:0] remote_slope_i, // remote slope
  input wire logic pec_required_o, // checksum mandatory
  input wire logic droop_slope_select_o, // droop style
  input wire logic adaptive_ramp_loop_comp_o, // ramp and loop comp
  input wire logic dynamic_bus_voltage_o, // bus voltage feature
  input wire logic log_done_o, // log complete
  input wire logic [31:0] feedforward_o, // feed-forward block
  input wire logic [215:0] loop_filter_o // loop filter block
);
  // ----------------------------------------------------------------
  // helper and checks
  // ----------------------------------------------------------------
  logic [255:0] wd_ff; // write block of the previous edge
  // keep last write block
  always_ff @(posedge sys_clk_i) begin
    wd_ff <= wr_data_i;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  chk_opts_read: assert property (
    rd_stb_i && cmd_code_i == pmc_pkg::CMD_SPECIAL_OPT |=> rd_valid_o
    && rd_len_o == 6'h01 && rd_data_o[7:0] == {pec_required_o, 1'b0,
    droop_slope_select_o, 1'b0, adaptive_ramp_loop_comp_o,
    dynamic_bus_voltage_o, 2'b00}) else $error("options read wrong");
  chk_log_len: assert property (
    rd_stb_i && cmd_code_i == pmc_pkg::CMD_STARTUP_LOG |=> rd_valid_o
    && rd_len_o == 6'h20) else $error("log read length wrong");
  chk_cal_pair: assert property (
    rd_stb_i && cmd_code_i == pmc_pkg::CMD_REMOTE_CAL |=> rd_len_o == 6'h04
    && rd_data_o[31:0] == {$past(remote_slope_i), $past(remote_ofs_i)})
    else $error("calibration read wrong");
  chk_ff_write: assert property (
    wr_stb_i && cmd_code_i == pmc_pkg::CMD_FEEDFORWARD && wr_len_i == 6'h04
    && (wr_pec_ok_i || !pec_required_o) |=> feedforward_o == wd_ff[31:0])
    else $error("feed-forward write lost");
  chk_lf_write: assert property (
    wr_stb_i && cmd_code_i == pmc_pkg::CMD_LOOP_FILTER && wr_len_i == 6'h1B
    && (wr_pec_ok_i || !pec_required_o) |=> loop_filter_o == wd_ff[215:0])
    else $error("loop filter write lost");
  chk_pec_refuse: assert property (
    wr_stb_i && pec_required_o && !wr_pec_ok_i |=> cmd_err_o
    && pec_required_o) else $error("unchecked write accepted");
  chk_log_hold: assert property (
    log_done_o |=> log_done_o ##1 log_done_o) else $error("log reopened");
  chk_bad_read: assert property (
    rd_stb_i && cmd_code_i == 8'hE4 |=> cmd_err_o && !rd_valid_o)
    else $error("unknown read answered");
endmodule
bind pmc_cfg_bank pmc_cfg_checker u_chk (.*);

// ### testbench/pmc_host_model.sv
// Purpose: host controller issuing command transactions
// Assumes: strobes taken on the rising edge, answer one cycle later
// Notes: released lines show inverted values, not the last ones
`timescale 1ns/1ps
module pmc_host_model (
  input wire logic sys_clk_i, // system clock
  input wire logic [255:0] rd_data_i, // read block
  input wire logic [5:0] rd_len_i, // read byte count
  input wire logic rd_valid_i, // read answer
  input wire logic cmd_err_i, // refused command
  output logic [7:0] cmd_code_o, // command code
  output logic wr_stb_o, // write pulse
  output logic [255:0] wr_data_o, // write block
  output logic [5:0] wr_len_o, // write byte count
  output logic wr_pec_ok_o, // checksum appended
  output logic rd_stb_o // read pulse
);
  // ----------------------------------------------------------------
  // transaction tasks
  // ----------------------------------------------------------------
  initial begin
    cmd_code_o = 8'h00;
    wr_stb_o = 1'b0;
    wr_data_o = 256'h0;
    wr_len_o = 6'h00;
    wr_pec_ok_o = 1'b0;
    rd_stb_o = 1'b0;
  end
  // drop strobes and scramble the qualifiers
  task automatic idle();
    wr_stb_o = 1'b0;
    rd_stb_o = 1'b0;
    cmd_code_o = ~cmd_code_o;
    wr_data_o = ~wr_data_o;
    wr_len_o = ~wr_len_o;
    wr_pec_ok_o = ~wr_pec_ok_o;
  endtask
  // valid checksum always appended unless told to spoil it
  task automatic wr(input logic [7:0] c, input logic [5:0] n,
      input logic [255:0] d, input bit spoil, output logic e);
    @(negedge sys_clk_i);
    cmd_code_o = c;
    wr_len_o = n;
    wr_data_o = d;
    wr_pec_ok_o = !spoil;
    wr_stb_o = 1'b1;
    @(negedge sys_clk_i);
    e = cmd_err_i;
    idle();
  endtask
  // one read, answer taken in the following cycle
  task automatic rd(input logic [7:0] c, output logic [255:0] q,
      output logic [5:0] n, output logic v, output logic e);
    @(negedge sys_clk_i);
    cmd_code_o = c;
    rd_stb_o = 1'b1;
    @(negedge sys_clk_i);
    q = rd_data_i;
    n = rd_len_i;
    v = rd_valid_i;
    e = cmd_err_i;
    idle();
  endtask
endmodule

// ### testbench/testbench.sv
// Purpose: self-checking bench of the configuration bank
// Assumes: log interval shortened to 20 cycles
// Notes: inputs change on the falling edge only
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
  begin \
    samples_checked++; \
    if ((ex) !== (gt)) begin \
      bad_count++; \
      $display("Error %s: expected %0h, seen %0h", nm, ex, gt); \
    end \
  end
module testbench;
  logic sys_clk_i = 1'b0, srst_i = 1'b1, ramp_done_i = 1'b0;
  logic [7:0] cmd_code_i;
  logic wr_stb_i, wr_pec_ok_i, rd_stb_i, rd_valid_o, cmd_err_o;
  logic [255:0] wr_data_i, rd_data_o, d, q, p;
  logic [5:0] wr_len_i, rd_len_o, n;
  logic [15:0] status_word_i = 16'h0000, int_temp_ofs_i = 16'h0000;
  logic [15:0] remote_ofs_i = 16'h0000, remote_slope_i = 16'h0000, t0;
  logic [47:0] temp_comp_i = 48'h0;
  logic primary_remote_input_i = 1'b0, ctrl_pin_i = 1'b0;
  logic operation_on_i = 1'b0, v, e, pec_required_o, droop_slope_select_o;
  logic adaptive_ramp_loop_comp_o, dynamic_bus_voltage_o, output_on_o;
  logic quick_off_o, log_done_o;
  logic [31:0] feedforward_o;
  logic [215:0] loop_filter_o;
  logic [127:0] nl_gains_o;
  logic [7:0] o;
  int bad_count = 0, samples_checked = 0, k;
  pmc_cfg_bank #(.LOG_INTERVAL_CYC(32'h0000_0014)) DUT (.*);
  pmc_host_model u_host (.sys_clk_i(sys_clk_i), .rd_data_i(rd_data_o),
    .rd_len_i(rd_len_o), .rd_valid_i(rd_valid_o), .cmd_err_i(cmd_err_o),
    .cmd_code_o(cmd_code_i), .wr_stb_o(wr_stb_i), .wr_data_o(wr_data_i),
    .wr_len_o(wr_len_i), .wr_pec_ok_o(wr_pec_ok_i), .rd_stb_o(rd_stb_i));
  // ----------------------------------------------------------------
  // clock, status counter, helpers
  // ----------------------------------------------------------------
  always #2.5 sys_clk_i = ~sys_clk_i;
  // live status word counts cycles so capture times show
  always @(negedge sys_clk_i) begin
    status_word_i <= status_word_i + 16'h0001;
  end
  // expected combined output enable
  function automatic logic exp_on(logic [7:0] c, logic pin, ct, op);
    logic a, t;
    a = c[1] ? pin : !pin;
    t = c[2] ? a : c[4];
    return c[4] ? (op & ct & t) : (op | ct | t);
  endfunction
  // random wide value cut to n bytes
  function automatic logic [255:0] rnd(logic [5:0] n);
    logic [255:0] r;
    for (int i = 0; i < 8; i++) r[32*i+:32] = $urandom;
    return r & ((256'h1 << (8 * n)) - 256'h1);
  endfunction
  task automatic test_done();
    $display("checked %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    bad_count++;
    test_done();
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(17562));
    repeat (3) @(negedge sys_clk_i);
    srst_i = 1'b0;
    `CHK("opts_rst", 4'h0, {pec_required_o, droop_slope_select_o, adaptive_ramp_loop_comp_o, dynamic_bus_voltage_o})
    for (k = 0; k < 4; k++) begin
      @(negedge sys_clk_i);
      int_temp_ofs_i = 16'($urandom);
      remote_ofs_i = 16'($urandom);
      remote_slope_i = 16'($urandom);
      temp_comp_i = {16'($urandom), 32'($urandom)};
      u_host.rd(8'hE1, q, n, v, e);
      `CHK("int_temp", {6'h02, int_temp_ofs_i}, {n, q[15:0]})
      u_host.rd(8'hE2, q, n, v, e);
      `CHK("remote_cal", {remote_slope_i, remote_ofs_i}, q[31:0])
      u_host.rd(8'hE7, q, n, v, e);
      `CHK("temp_comp", {6'h06, temp_comp_i}, {n, q[47:0]})
    end
    u_host.wr(8'hE1, 6'h02, 256'h1, 1'b0, e);
    `CHK("ro_write_err", 1'b1, e)
    u_host.rd(8'hE4, q, n, v, e);
    `CHK("unknown_read", 2'b01, {v, e})
    for (k = 0; k < 12; k++) begin
      o = (k == 11) ? 8'h80 : 8'($urandom);
      u_host.wr(8'hE0, 6'h01, {248'h0, o}, 1'b0, e);
      u_host.rd(8'hE0, q, n, v, e);
      `CHK("opts_read", o & 8'hAC, q[7:0])
      `CHK("opts_out", {o[7], o[5], o[3], o[2]}, {pec_required_o, droop_slope_select_o, adaptive_ramp_loop_comp_o, dynamic_bus_voltage_o})
    end
    u_host.wr(8'hE0, 6'h01, 256'h24, 1'b1, e);
    `CHK("pec_refuse", 3'b110, {e, pec_required_o, droop_slope_select_o})
    u_host.wr(8'hE0, 6'h02, 256'h04, 1'b0, e);
    `CHK("bad_len", 2'b10, {e, dynamic_bus_voltage_o})
    u_host.wr(8'hE0, 6'h01, 256'h00, 1'b0, e);
    u_host.wr(8'hE0, 6'h01, 256'h04, 1'b1, e);
    `CHK("pec_optional", 3'b001, {e, pec_required_o, dynamic_bus_voltage_o})
    for (k = 0; k < 6; k++) begin
      n = (k % 3 == 0) ? 6'h04 : (k % 3 == 1) ? 6'h1B : 6'h10;
      d = rnd(n);
      o = (k % 3 == 0) ? 8'hE6 : 8'hE7 + 8'(k % 3);
      u_host.wr(o, n, d, 1'b0, e);
      u_host.rd(o, q, p[5:0], v, e);
      `CHK("block_read", {n, d}, {p[5:0], q})
    end
    `CHK("nl_out", d[127:0], nl_gains_o)
    for (k = 0; k < 48; k++) begin
      o = 8'($urandom) & 8'h17;
      u_host.wr(8'hE3, 6'h01, {248'h0, o}, 1'b0, e);
      {primary_remote_input_i, ctrl_pin_i, operation_on_i} = 3'($urandom);
      repeat (8) @(negedge sys_clk_i);
      `CHK("output_on", exp_on(o, primary_remote_input_i, ctrl_pin_i, operation_on_i), output_on_o)
    end
    for (k = 0; k < 2; k++) begin
      u_host.wr(8'hE3, 6'h01, 256'h06 | k, 1'b0, e);
      {primary_remote_input_i, ctrl_pin_i, operation_on_i} = 3'b100;
      repeat (8) @(negedge sys_clk_i);
      primary_remote_input_i = 1'b0;
      repeat (8) @(negedge sys_clk_i);
      `CHK("quick_off", {1'b0, k[0]}, {output_on_o, quick_off_o})
    end
    ramp_done_i = 1'b1;
    t0 = status_word_i;
    for (k = 0; k < 1000 && log_done_o !== 1'b1; k++) @(negedge sys_clk_i);
    u_host.rd(8'hDF, q, n, v, e);
    `CHK("log_len", 6'h20, n)
    `CHK("log_start", 1'b1, (q[15:0] - t0) inside {[16'd1:16'd12]})
    for (k = 1; k < 16; k++) `CHK("log_word", q[15:0] + 16'(20 * k), q[16*k+:16])
    repeat (60) @(negedge sys_clk_i);
    u_host.rd(8'hDF, p, n, v, e);
    `CHK("log_hold", {1'b1, q}, {log_done_o, p})
    test_done();
  end
endmodule
